// *** uvt_consts.vh ***
// constants for the usb interface control and timing registers
// Operation
// - power switch follows bit 1 of the control register, 1 on, 0 off.
// - power switch bit resets to 1 when bus supply present, else 0.
// - writing 1 to control bit 2 restarts the whole block logic.
// - after restart the restart flag sets and bit 2 clears by itself.
// - auto low power bit 5 set: idle entry automatic, host entry ignored.
// - auto low power bit 5 clear: low power only on host request.
// - bit 6 closes left speaker to minus data switch, 0 opens it.
// - test registers 0x24-0x26 reachable only while bit 7 is 1.
// - accessory id waits (n+1) x 100 ms after bus voltage, reset code 4.
// - audio or tty idle for (n+1) s enters low power, reset code 9.
// - reading the mode register clears the restart flag.
// - a read-only status bit shows the actual power switch state.
`ifndef UVT_CONSTS_VH
`define UVT_CONSTS_VH
// ****************************************
// register addresses
// ****************************************
`define UVT_ADDR_STATUS    8'h0D
`define UVT_ADDR_CTRL      8'h0E
`define UVT_ADDR_DELAY     8'h0F
`define UVT_ADDR_MODE      8'h10
`define UVT_ADDR_TEST_LO   8'h24
`define UVT_ADDR_TEST_HI   8'h26
// ****************************************
// field positions
// ****************************************
`define UVT_CTRL_PWR_BIT   1
`define UVT_CTRL_RST_BIT   2
`define UVT_CTRL_AUTO_BIT  5
`define UVT_CTRL_TTY_BIT   6
`define UVT_CTRL_TEST_BIT  7
`define UVT_MODE_FLAG_BIT  0
`define UVT_MODE_ACT_BIT   1
`define UVT_MODE_LP_BIT    2
`define UVT_STAT_PWR_BIT   6
// ****************************************
// reset values
// ****************************************
`define UVT_RST_AUTO       1'b1
`define UVT_RST_ID_CODE    4'h4
`define UVT_RST_IDLE_CODE  4'h9
// ****************************************
// timing
// ****************************************
`define UVT_CLK_MHZ        125
`define UVT_TICK_US        1000
`define UVT_TICK_CYCLES    (`UVT_CLK_MHZ * `UVT_TICK_US)
`define UVT_ID_STEP_MS     100
`define UVT_IDLE_STEP_MS   1000
`endif

// *** uvt_tick_div.v ***
// divider giving a one-cycle millisecond enable
`include "uvt_consts.vh"
module uvt_tick_div #(
  parameter DIV = `UVT_TICK_CYCLES
) (
  input  wire clock_i,
  input  wire rst_i,
  output reg  tick_o
);
  reg [31:0] cnt_q;
  always @(posedge clock_i) begin
    if (rst_i) begin
      cnt_q  <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (cnt_q == DIV - 1) begin
      cnt_q  <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule

// *** uvt_delay_cnt.v ***
// stepped delay counter, (code+1) steps of step_ticks
module uvt_delay_cnt #(
  parameter CODE_W     = 4,
  parameter CNT_W      = 16,
  parameter STEP_TICKS = 100
) (
  input  wire              clock_i,
  input  wire              rst_i,
  input  wire              tick_i,
  input  wire              run_i,
  input  wire              start_i,
  input  wire [CODE_W-1:0] code_i,
  output reg               done_o
);
  reg [CNT_W-1:0] cnt_q;
  reg             armed_q;
  wire [CNT_W-1:0] load = ({{(CNT_W-CODE_W){1'b0}}, code_i} + 1'b1)
                          * STEP_TICKS[CNT_W-1:0] - 1'b1;
  always @(posedge clock_i) begin
    if (rst_i) begin
      cnt_q   <= {CNT_W{1'b0}};
      armed_q <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!run_i) begin
        armed_q <= 1'b0;
      end else if (start_i) begin
        cnt_q   <= load;
        armed_q <= 1'b1;
      end else if (armed_q && tick_i) begin
        if (cnt_q == {CNT_W{1'b0}}) begin
          armed_q <= 1'b0;
          done_o  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule

// *** uvt_regs.v ***
// control and timing register bank with restart, low power and id delay
`include "uvt_consts.vh"
module uvt_regs #(
  parameter TICK_CYCLES = `UVT_TICK_CYCLES
) (
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire       vbus_present_i,
  input  wire       power_switch_state_i,
  input  wire       accessory_audio_i,
  input  wire       switch_activity_i,
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_wdata_i,
  input  wire [7:0] test_rdata_i,
  output reg  [7:0] reg_rdata_o,
  output reg        reg_rvalid_o,
  output reg        power_switch_on_o,
  output reg        tty_left_speaker_route_o,
  output reg        low_power_state_o,
  output reg        id_start_o,
  output reg        test_wr_o,
  output reg        test_rd_o,
  output reg  [7:0] test_addr_o,
  output reg  [7:0] test_wdata_o
);
  // ****************************************
  // decode
  // ****************************************
  function is_test;
    input [7:0] a;
    begin
      is_test = (a >= `UVT_ADDR_TEST_LO) && (a <= `UVT_ADDR_TEST_HI);
    end
  endfunction

  reg        soft_rst_q;
  reg        auto_q;
  reg        test_unlock_q;
  reg        active_q;
  reg        flag_q;
  reg [3:0]  id_code_q;
  reg [3:0]  idle_code_q;
  reg        vbus_q;
  reg        idle_run_q;
  wire       lrst = rst_i | soft_rst_q;
  wire       wr_ctrl = reg_wr_i && (reg_addr_i == `UVT_ADDR_CTRL);
  wire       wr_delay = reg_wr_i && (reg_addr_i == `UVT_ADDR_DELAY);
  wire       wr_mode = reg_wr_i && (reg_addr_i == `UVT_ADDR_MODE);
  wire       rd_mode = reg_rd_i && (reg_addr_i == `UVT_ADDR_MODE);
  wire       test_ok = test_unlock_q;
  wire       tick;
  wire       id_done;
  wire       idle_done;
  wire       idle_run = auto_q && accessory_audio_i && !low_power_state_o;
  wire       idle_start = switch_activity_i || (idle_run && !idle_run_q);

  // ****************************************
  // timers
  // ****************************************
  uvt_tick_div #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .clock_i (clock_i),
    .rst_i   (lrst),
    .tick_o  (tick)
  );

  uvt_delay_cnt #(
    .CODE_W     (4),
    .CNT_W      (16),
    .STEP_TICKS (`UVT_ID_STEP_MS)
  ) u_id (
    .clock_i (clock_i),
    .rst_i   (lrst),
    .tick_i  (tick),
    .run_i   (vbus_present_i),
    .start_i (vbus_present_i && !vbus_q),
    .code_i  (id_code_q),
    .done_o  (id_done)
  );

  uvt_delay_cnt #(
    .CODE_W     (4),
    .CNT_W      (16),
    .STEP_TICKS (`UVT_IDLE_STEP_MS)
  ) u_idle (
    .clock_i (clock_i),
    .rst_i   (lrst),
    .tick_i  (tick),
    .run_i   (idle_run),
    .start_i (idle_start),
    .code_i  (idle_code_q),
    .done_o  (idle_done)
  );

  // ****************************************
  // soft restart and restart flag
  // ****************************************
  always @(posedge clock_i) begin
    if (rst_i) begin
      soft_rst_q <= 1'b0;
      flag_q     <= 1'b1;
    end else begin
      soft_rst_q <= wr_ctrl && reg_wdata_i[`UVT_CTRL_RST_BIT];
      if (soft_rst_q) begin
        flag_q <= 1'b1;
      end else if (rd_mode) begin
        flag_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // control and delay registers
  // ****************************************
  always @(posedge clock_i) begin
    if (lrst) begin
      power_switch_on_o        <= vbus_present_i;
      auto_q                   <= `UVT_RST_AUTO;
      tty_left_speaker_route_o <= 1'b0;
      test_unlock_q            <= 1'b0;
      id_code_q                <= `UVT_RST_ID_CODE;
      idle_code_q              <= `UVT_RST_IDLE_CODE;
      active_q                 <= 1'b0;
      vbus_q                   <= 1'b0;
      idle_run_q               <= 1'b0;
      id_start_o               <= 1'b0;
    end else begin
      vbus_q     <= vbus_present_i;
      idle_run_q <= idle_run;
      id_start_o <= id_done;
      if (wr_ctrl) begin
        power_switch_on_o        <= reg_wdata_i[`UVT_CTRL_PWR_BIT];
        auto_q                   <= reg_wdata_i[`UVT_CTRL_AUTO_BIT];
        tty_left_speaker_route_o <= reg_wdata_i[`UVT_CTRL_TTY_BIT];
        test_unlock_q            <= reg_wdata_i[`UVT_CTRL_TEST_BIT];
      end
      if (wr_delay) begin
        id_code_q   <= reg_wdata_i[3:0];
        idle_code_q <= reg_wdata_i[7:4];
      end
      if (wr_mode) begin
        active_q <= reg_wdata_i[`UVT_MODE_ACT_BIT];
      end
    end
  end

  // ****************************************
  // low power state
  // ****************************************
  always @(posedge clock_i) begin
    if (lrst) begin
      low_power_state_o <= 1'b0;
    end else if (auto_q) begin
      if (idle_done) begin
        low_power_state_o <= 1'b1;
      end else if (switch_activity_i) begin
        low_power_state_o <= 1'b0;
      end
    end else if (wr_mode) begin
      low_power_state_o <= reg_wdata_i[`UVT_MODE_LP_BIT];
    end
  end

  // ****************************************
  // read port and test register gate
  // ****************************************
  always @(posedge clock_i) begin
    if (lrst) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
      test_wr_o    <= 1'b0;
      test_rd_o    <= 1'b0;
      test_addr_o  <= 8'h00;
      test_wdata_o <= 8'h00;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      test_wr_o    <= reg_wr_i && is_test(reg_addr_i) && test_ok;
      test_rd_o    <= reg_rd_i && is_test(reg_addr_i) && test_ok;
      test_addr_o  <= reg_addr_i;
      test_wdata_o <= reg_wdata_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `UVT_ADDR_STATUS: reg_rdata_o <= {1'b0, power_switch_state_i, 6'b00_0000};
          `UVT_ADDR_CTRL:   reg_rdata_o <= {test_unlock_q, tty_left_speaker_route_o,
                                            auto_q, 2'b00, soft_rst_q,
                                            power_switch_on_o, 1'b0};
          `UVT_ADDR_DELAY:  reg_rdata_o <= {idle_code_q, id_code_q};
          `UVT_ADDR_MODE:   reg_rdata_o <= {5'b0_0000, low_power_state_o, active_q, flag_q};
          default:          reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule

// *** uvt_host.sv ***
// host model issuing decoded register accesses
module uvt_host (
  input  wire        clock_i,
  input  wire [7:0]  rdata_i,
  input  wire        rvalid_i,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic       wr_o = 1'b0,
  output logic       rd_o = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rvalid_i ? rdata_i : 8'hxx;
  endtask
endmodule

// *** uvt_regs_sva.sv ***
// port checker for the register bank
module uvt_chk #(
  parameter TICK_CYCLES = 125000
) (
  input wire       clock_i,
  input wire       rst_i,
  input wire       vbus_present_i,
  input wire       power_switch_state_i,
  input wire [7:0] reg_addr_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire       power_switch_on_o,
  input wire       tty_left_speaker_route_o,
  input wire       low_power_state_o,
  input wire       id_start_o,
  input wire       test_wr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [31:0] vb_q = '0;
  always @(posedge clock_i) vb_q <= vbus_present_i ? vb_q + 1 : '0;
  sequence s_ctl; reg_wr_i && reg_addr_i == 8'h0E; endsequence
  sequence s_mrd; reg_rd_i && reg_addr_i == 8'h10; endsequence
  sequence s_twr; reg_wr_i && reg_addr_i >= 8'h24 && reg_addr_i <= 8'h26; endsequence
  property p_pwr; s_ctl and !reg_wdata_i[2] |=> power_switch_on_o == $past(reg_wdata_i[1]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power switch mismatch");
  property p_tty; s_ctl and !reg_wdata_i[2] |=> tty_left_speaker_route_o == $past(reg_wdata_i[6]);
  endproperty
  a_tty: assert property (p_tty) else $error("speaker route mismatch");
  property p_rpwr; $fell(rst_i) |-> power_switch_on_o == $past(vbus_present_i); endproperty
  a_rpwr: assert property (p_rpwr) else $error("power reset value wrong");
  property p_soft; s_ctl and reg_wdata_i[2] |-> ##3 !tty_left_speaker_route_o
    && !low_power_state_o && power_switch_on_o == $past(vbus_present_i); endproperty
  a_soft: assert property (p_soft) else $error("soft restart missing");
  property p_topen; test_wr_o |-> $past(reg_wr_i && reg_addr_i >= 8'h24 && reg_addr_i <= 8'h26);
  endproperty
  a_topen: assert property (p_topen) else $error("stray test strobe");
  property p_tlock; (s_ctl and !reg_wdata_i[7] && !reg_wdata_i[2]) ##[1:4] s_twr |=> !test_wr_o;
  endproperty
  a_tlock: assert property (p_tlock) else $error("locked test access passed");
  property p_stat; reg_rd_i && reg_addr_i == 8'h0D |=> reg_rdata_o[6] == $past(power_switch_state_i);
  endproperty
  a_stat: assert property (p_stat) else $error("switch state bit wrong");
  property p_clr; s_mrd ##[1:4] s_mrd |=> !reg_rdata_o[0]; endproperty
  a_clr: assert property (p_clr) else $error("restart flag not cleared");
  property p_id; $rose(id_start_o) |-> vb_q >= 99 * TICK_CYCLES; endproperty
  a_id: assert property (p_id) else $error("id start too early");
endmodule
bind uvt_regs uvt_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clock_i, .rst_i, .vbus_present_i,
  .power_switch_state_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
  .power_switch_on_o, .tty_left_speaker_route_o, .low_power_state_o, .id_start_o, .test_wr_o);

// *** tb.sv ***
// self-checking bench for the register bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       vbus = 1'b1, pss = 1'b0, aud = 1'b0, act = 1'b0;
  logic [7:0] addr, wdata, rdata, taddr, twd, d;
  logic       wr, rd, rvalid, pwr, tty, lp, ids, twr, trd;
  int         error_cnt = 0, compares = 0, cyc = 0, n;
  always #4 clock_i = ~clock_i;
  uvt_regs #(.TICK_CYCLES(10)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
    .vbus_present_i(vbus), .power_switch_state_i(pss), .accessory_audio_i(aud),
    .switch_activity_i(act), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .test_rdata_i(8'h00), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .power_switch_on_o(pwr), .tty_left_speaker_route_o(tty), .low_power_state_o(lp),
    .id_start_o(ids), .test_wr_o(twr), .test_rd_o(trd), .test_addr_o(taddr),
    .test_wdata_o(twd));
  uvt_host host_u (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
    host_u.rd(a, d);
    chk(d, e, m);
  endtask
  task automatic wait_for(input bit want_lp, input int lim);
    n = 0;
    while ((want_lp ? lp : ids) !== 1'b1 && n < lim) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  task automatic t_reset;
    rdc(8'h0E, 8'h22, "ctrl reset");
    rdc(8'h0F, 8'h94, "delay reset");
    rdc(8'h10, 8'h01, "flag set");
    rdc(8'h10, 8'h00, "flag clear");
  endtask
  task automatic t_ctrl;
    host_u.wr(8'h0E, 8'h40);
    #1 chk({6'h00, pwr, tty}, 8'h01, "switch outputs");
    rdc(8'h0E, 8'h40, "ctrl readback");
    host_u.wr(8'h0E, 8'h02);
    #1 chk({6'h00, pwr, tty}, 8'h02, "switch on route open");
    rdc(8'h0D, 8'h00, "switch state off");
    @(posedge clock_i) pss <= 1'b1;
    rdc(8'h0D, 8'h40, "switch state on");
  endtask
  task automatic t_lp;
    host_u.wr(8'h10, 8'h04);
    #1 chk({7'h00, lp}, 8'h01, "host low power");
    host_u.wr(8'h10, 8'h00);
    host_u.wr(8'h0E, 8'h20);
    host_u.wr(8'h10, 8'h04);
    #1 chk({7'h00, lp}, 8'h00, "host low power refused");
  endtask
  task automatic t_test;
    host_u.wr(8'h25, 8'h5A);
    #1 chk({7'h00, twr}, 8'h00, "locked test");
    host_u.rd(8'h24, d);
    chk({7'h00, trd}, 8'h00, "locked test read");
    host_u.wr(8'h0E, 8'hA0);
    for (int a = 8'h23; a <= 8'h27; a++) begin
      host_u.wr(a[7:0], 8'h5A);
      #1 chk({7'h00, twr}, {7'h00, a >= 8'h24 && a <= 8'h26}, "test strobe");
      chk(taddr, a[7:0], "test address");
      chk(twd, 8'h5A, "test data");
    end
    host_u.rd(8'h26, d);
    chk({7'h00, trd}, 8'h01, "open test read");
  endtask
  task automatic t_timers;
    host_u.wr(8'h0F, 8'h16);
    @(posedge clock_i) vbus <= 1'b0;
    repeat (3) @(posedge clock_i);
    vbus <= 1'b1;
    wait_for(1'b0, 9000);
    chk({7'h00, n >= 6988 && n <= 7005}, 8'h01, "id delay");
    @(posedge clock_i) aud <= 1'b1;
    act <= 1'b1;
    @(posedge clock_i) act <= 1'b0;
    wait_for(1'b1, 25000);
    chk({7'h00, n >= 19985 && n <= 20005}, 8'h01, "idle entry");
    @(posedge clock_i) act <= 1'b1;
    @(posedge clock_i) act <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({7'h00, lp}, 8'h00, "activity wakes");
    aud <= 1'b0;
  endtask
  task automatic t_restart;
    host_u.wr(8'h0E, 8'h44);
    repeat (3) @(posedge clock_i);
    rdc(8'h0E, 8'h22, "restart ctrl");
    rdc(8'h0F, 8'h94, "restart delay");
    rdc(8'h10, 8'h01, "restart flag");
  endtask
  task automatic t_rst;
    @(posedge clock_i);
    rst_i <= 1'b1;
    vbus  <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    rdc(8'h0E, 8'h20, "ctrl reset no supply");
    chk({7'h00, pwr}, 8'h00, "switch off no supply");
    vbus <= 1'b1;
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset;
    t_ctrl;
    t_lp;
    t_test;
    t_timers;
    t_restart;
    t_rst;
    tally_and_finish;
  end
endmodule
